// ===== esfe_bench.sv
`timescale 1ns/1ps
`default_nettype none
module esfe_bench;
	import esfe_pkg::*;
	localparam int WC = 1000;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, busy, wp, err;
	logic [2:0]  cs;
	logic [6:0]  a;
	logic [7:0]  paddr, s, d;
	logic [9:0]  word_addr;
	logic [31:0] pwdata, prdata, rd, st;
	int          seed, miscompares, cmp_count;

	esfe_link_if link_if();
	esfe_device #(.WRITE_CYCLE(WC)) esfe_device_inst (.clk(clk), .nrst(nrst), .link(link_if),
		.chip_select_strap_bit0(cs[0]), .chip_select_strap_bit1(cs[1]),
		.chip_select_strap_bit2(cs[2]), .write_protect(wp), .busy(busy), .word_addr(word_addr));
	esfe_host esfe_host_inst (.clk(clk), .nrst(nrst), .link(link_if), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	esfe_props #(.WRITE_CYCLE(WC)) esfe_props_inst (.clk(clk), .nrst(nrst), .scl(link_if.scl),
		.sda(link_if.sda), .sda_out_d(link_if.sda_out_d), .sda_oe_n_d(link_if.sda_oe_n_d),
		.chip_select_strap_bit0(cs[0]), .chip_select_strap_bit1(cs[1]),
		.chip_select_strap_bit2(cs[2]), .busy(busy));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic stop_test;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [7:0] exp_read(input logic prot, input logic [6:0] ad,
		input logic [7:0] old_b, input logic [7:0] new_b);
		return (prot && ad[PROTECT_BIT]) ? old_b : new_b;
	endfunction

	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
		output logic [31:0] rdat, output logic perr);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= ad;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Values read at the edge are those the slave shows as the edge samples them
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		rdat = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			stop_test;
		end
	endtask

	task automatic cmd(input logic rw, input logic [2:0] sel, output logic [31:0] sts);
		int n;
		apb(1'b1, REG_CMD, {27'h0, sel, rw, 1'b1}, rd, err);
		n = 0;
		sts = 32'h1;
		while (sts[STATUS_BUSY_BIT] !== 1'b0 && n < 2000) begin
			apb(1'b0, REG_STATUS, 32'h0, sts, err);
			n++;
		end
		if (n >= 2000) begin
			miscompares++;
			stop_test;
		end
	endtask

	task automatic wr(input logic [6:0] ad, input logic [7:0] dat, output logic [31:0] sts);
		apb(1'b1, REG_ADDR, {25'h0, ad}, rd, err);
		apb(1'b1, REG_WDATA, {24'h0, dat}, rd, err);
		cmd(1'b0, cs, sts);
	endtask

	task automatic idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		repeat (4) @(posedge clk);
		if (n >= 5000) begin
			miscompares++;
			stop_test;
		end
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#600_000;
		miscompares++;
		stop_test;
	end

	initial begin
		seed        = 85;
		miscompares = 0;
		cmp_count   = 0;
		nrst        = 1'b0;
		psel        = 1'b0;
		penable     = 1'b0;
		pwrite      = 1'b0;
		paddr       = 8'h00;
		pwdata      = 32'h0;
		wp          = 1'b0;
		cs          = 3'($random(seed));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0, rd, err);
		chk_val("unmapped error", 32'h1, {31'h0, err});
		chk_val("unmapped data", 32'h0, rd);
		// Writes, not reads: the array is unwritten here and would send unknowns
		for (int i = 0; i < 8; i++) begin
			cmd(1'b0, i[2:0], st);
			chk_val("select nack", {31'h0, i[2:0] != cs}, {31'h0, st[STATUS_NACK_BIT]});
			idle;
		end
		for (int t = 0; t < 6; t++) begin
			// Low nibble kept non-zero so the pad write below stays in the page
			a = (t == 0) ? 7'h41 : (t == 1) ? 7'h3f : 7'($random(seed));
			if (a[3:0] == 4'h0) begin
				a[3:0] = 4'h5;
			end
			s = 8'($random(seed));
			d = 8'($random(seed));
			wp <= 1'b0;
			wr(a, s, st);
			chk_val("write ack", 32'h0, {31'h0, st[STATUS_NACK_BIT]});
			apb(1'b0, REG_ADDR, 32'h0, rd, err);
			chk_val("addr reg", {25'h0, a}, rd);
			cmd(1'b1, cs, st);
			chk_val("busy nack", 32'h1, {31'h0, st[STATUS_NACK_BIT]});
			idle;
			wp <= 1'($random(seed));
			wr(a, d, st);
			idle;
			wr(a - 7'h1, ~d, st);
			idle;
			chk_val("pointer", {22'h0, cs, a}, {22'h0, word_addr});
			cmd(1'b1, cs, st);
			chk_val("read data", {24'h0, exp_read(wp, a, s, d)}, {24'h0, st[15:8]});
			chk_val("pointer step", {22'h0, cs, 7'(a + 7'h1)}, {22'h0, word_addr});
			cs <= 3'($random(seed));
			repeat (8) @(posedge clk);
		end
		stop_test;
	end
endmodule
`default_nettype wire

// ===== esfe_device.sv
`timescale 1ns/1ps
`default_nettype none
module esfe_device #(
	parameter int WRITE_CYCLE = esfe_pkg::WRITE_CYCLE_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	esfe_link_if.dev        link,
	input  wire logic       chip_select_strap_bit0,
	input  wire logic       chip_select_strap_bit1,
	input  wire logic       chip_select_strap_bit2,
	input  wire logic       write_protect,
	output var  logic       busy,
	output var  logic [9:0] word_addr
);
	import esfe_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE,
		S_RX,
		S_ACK,
		S_TX,
		S_TXACK,
		S_IGNORE
	} esfe_dev_state_t;

	localparam int TW = $clog2(WRITE_CYCLE + 1);

	esfe_dev_state_t state;
	logic [5:0]      pins_s;
	logic            scl_s;
	logic            sda_s;
	logic [2:0]      cs_s;
	logic            wp_s;
	logic            scl_q;
	logic            sda_q;
	logic            scl_rise;
	logic            scl_fall;
	logic            start_cond;
	logic            stop_cond;
	logic [3:0]      bit_cnt;
	logic [7:0]      shreg;
	logic [1:0]      byte_idx;
	logic            is_read;
	logic            addressed;
	logic            mack;
	logic            byte_done;
	logic            ctrl_ok;
	logic            tx_load;
	logic            tx_done;
	logic            commit;
	logic [6:0]      ptr;
	logic [7:0]      mem [MEM_BYTES];
	logic [7:0]      pbuf [PAGE_BYTES];
	logic [15:0]     pvalid;
	logic [TW-1:0]   timer;

	//--------------------------------------------------
	// Pin capture and bus conditions
	//--------------------------------------------------
	esfe_sync #(
		.WIDTH (6),
		.INIT  (6'h3f)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    ({write_protect, chip_select_strap_bit2, chip_select_strap_bit1,
			chip_select_strap_bit0, link.sda, link.scl}),
		.q    (pins_s)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign cs_s  = pins_s[4:2];
	assign wp_s  = pins_s[5];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise   = scl_s & ~scl_q;
	assign scl_fall   = ~scl_s & scl_q;
	// Data moving under a steady high clock is never a bit
	assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_cond  = scl_s & scl_q & ~sda_q & sda_s;

	//--------------------------------------------------
	// Byte events
	//--------------------------------------------------
	assign byte_done = (state == S_RX) && scl_fall && (bit_cnt == 4'd8);
	// Type code, select bits, then direction in bit 0
	assign ctrl_ok   = (shreg[7:4] == TYPE_CODE) && (shreg[3:1] == cs_s) && !busy;
	assign tx_load   = scl_fall && (((state == S_ACK) && is_read) || ((state == S_TXACK) && mack));
	assign tx_done   = (state == S_TX) && scl_fall && (bit_cnt == 4'd7);
	assign commit    = stop_cond && addressed && !is_read && (|pvalid);

	//--------------------------------------------------
	// Bit engine
	//--------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state      <= S_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			byte_idx   <= 2'h0;
			is_read    <= 1'b0;
			addressed  <= 1'b0;
			mack       <= 1'b0;
			link.sda_oe_n_d <= 1'b1;
		end else if (start_cond) begin
			state      <= S_RX;
			bit_cnt    <= 4'h0;
			byte_idx   <= 2'h0;
			addressed  <= 1'b0;
			link.sda_oe_n_d <= 1'b1;
		end else if (stop_cond) begin
			state      <= S_IDLE;
			addressed  <= 1'b0;
			link.sda_oe_n_d <= 1'b1;
		end else begin
			case (state)
				S_RX: begin
					if (scl_rise && bit_cnt != 4'd8) begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'd1;
					end else if (byte_done) begin
						if (byte_idx != 2'h0 || ctrl_ok) begin
							state           <= S_ACK;
							link.sda_oe_n_d <= 1'b0;
						end else begin
							state <= S_IGNORE;
						end
						if (byte_idx == 2'h0) begin
							is_read   <= shreg[0];
							addressed <= ctrl_ok;
						end
						if (byte_idx != 2'h2) begin
							byte_idx <= byte_idx + 2'h1;
						end
					end
				end
				S_ACK: begin
					// Low held over the whole ninth high phase
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (is_read) begin
							state           <= S_TX;
							shreg           <= mem[ptr];
							link.sda_oe_n_d <= mem[ptr][7];
						end else begin
							state           <= S_RX;
							link.sda_oe_n_d <= 1'b1;
						end
					end
				end
				S_TX: begin
					if (tx_done) begin
						state           <= S_TXACK;
						link.sda_oe_n_d <= 1'b1;
					end else if (scl_fall) begin
						shreg           <= {shreg[6:0], 1'b0};
						link.sda_oe_n_d <= shreg[6];
						bit_cnt         <= bit_cnt + 4'd1;
					end
				end
				S_TXACK: begin
					if (scl_rise) begin
						mack <= ~sda_s;
					end else if (tx_load) begin
						state           <= S_TX;
						bit_cnt         <= 4'h0;
						shreg           <= mem[ptr];
						link.sda_oe_n_d <= mem[ptr][7];
					end else if (scl_fall) begin
						// Line stays free so the master can issue Stop
						state <= S_IGNORE;
					end
				end
				default: begin
					link.sda_oe_n_d <= 1'b1;
				end
			endcase
		end
	end

	// Only ever pulls low; the enable carries the data
	always_ff @(posedge clk) begin
		if (!nrst) begin
			link.sda_out_d <= 1'b0;
		end else begin
			link.sda_out_d <= 1'b0;
		end
	end

	//--------------------------------------------------
	// Address pointer and page buffer
	//--------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ptr    <= RESET_PTR;
			pvalid <= 16'h0000;
		end else if (start_cond || commit) begin
			pvalid <= 16'h0000;
		end else if (byte_done && addressed && !is_read && byte_idx == 2'h1) begin
			ptr <= shreg[6:0];
		end else if (byte_done && addressed && !is_read && byte_idx == 2'h2) begin
			// Low nibble wraps, so a long burst keeps the last sixteen
			pbuf[ptr[3:0]]   <= shreg;
			pvalid[ptr[3:0]] <= 1'b1;
			ptr[3:0]         <= ptr[3:0] + 4'h1;
		end else if (tx_done) begin
			ptr <= ptr + 7'h01;
		end
	end

	//--------------------------------------------------
	// Timed write cycle
	//--------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy  <= 1'b0;
			timer <= '0;
		end else if (commit) begin
			// Cycle runs its full length even when protection drops the data
			busy  <= 1'b1;
			timer <= TW'(WRITE_CYCLE - 1);
		end else if (busy) begin
			if (timer == '0) begin
				busy <= 1'b0;
			end else begin
				timer <= timer - TW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (commit && !(wp_s && ptr[PROTECT_BIT])) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (pvalid[i]) begin
					mem[{ptr[6:4], 4'(i)}] <= pbuf[i];
				end
			end
		end
	end

	//--------------------------------------------------
	// Status out
	//--------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			word_addr <= 10'h000;
		end else begin
			word_addr <= {cs_s, ptr};
		end
	end

endmodule
`default_nettype wire

// ===== esfe_host.sv
`timescale 1ns/1ps
`default_nettype none
module esfe_host (
	input  wire logic        clk,
	input  wire logic        nrst,
	esfe_link_if.host        link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr
);
	import esfe_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} esfe_host_state_t;

	esfe_host_state_t state;
	logic             sda_s;
	logic [2:0]       div;
	logic             tick;
	logic [1:0]       phase;
	logic [1:0]       byte_n;
	logic [3:0]       bit_n;
	logic [7:0]       txbyte;
	logic [7:0]       rxsh;
	logic             slave_ack;
	logic             rx_mode;
	logic             last_byte;
	logic [2:0]       cs_sel;
	logic             rw;
	logic [6:0]       addr;
	logic [7:0]       wdata;
	logic [7:0]       rdata;
	logic             busy;
	logic             nack;
	logic             acc;
	logic             go;

	esfe_sync #(
		.WIDTH (1),
		.INIT  (1'b1)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.d    (link.sda),
		.q    (sda_s)
	);

	//--------------------------------------------------
	// APB registers
	//--------------------------------------------------
	assign acc = psel & penable & pready;
	// Bus must read idle before a command is launched
	assign go  = acc && pwrite && paddr == REG_CMD && pwdata[CMD_GO_BIT] && !busy && sda_s;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr != REG_CMD) & (paddr != REG_ADDR)
				& (paddr != REG_WDATA) & (paddr != REG_STATUS);
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == REG_CMD) begin
					prdata[CMD_RW_BIT]         <= rw;
					prdata[CMD_CS_LSB +: 3]    <= cs_sel;
				end else if (paddr == REG_ADDR) begin
					prdata[6:0] <= addr;
				end else if (paddr == REG_WDATA) begin
					prdata[7:0] <= wdata;
				end else if (paddr == REG_STATUS) begin
					prdata[STATUS_BUSY_BIT]        <= busy;
					prdata[STATUS_NACK_BIT]        <= nack;
					prdata[STATUS_RDATA_LSB +: 8]  <= rdata;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cs_sel <= 3'h0;
			rw     <= 1'b0;
			addr   <= 7'h00;
			wdata  <= 8'h00;
		end else if (acc && pwrite && !busy) begin
			if (paddr == REG_CMD) begin
				rw     <= pwdata[CMD_RW_BIT];
				cs_sel <= pwdata[CMD_CS_LSB +: 3];
			end else if (paddr == REG_ADDR) begin
				addr <= pwdata[6:0];
			end else if (paddr == REG_WDATA) begin
				wdata <= pwdata[7:0];
			end
		end
	end

	//--------------------------------------------------
	// Serial clock divider
	//--------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst || state == H_IDLE) begin
			div <= 3'h0;
		end else if (div == 3'(SCL_QUARTER_CYCLES - 1)) begin
			div <= 3'h0;
		end else begin
			div <= div + 3'h1;
		end
	end

	assign tick      = (state != H_IDLE) && (div == 3'(SCL_QUARTER_CYCLES - 1));
	assign rx_mode   = rw && byte_n == 2'h1;
	assign last_byte = rw ? byte_n == 2'h1 : byte_n == 2'h2;

	//--------------------------------------------------
	// Command sequencer
	//--------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state     <= H_IDLE;
			phase     <= 2'h0;
			byte_n    <= 2'h0;
			bit_n     <= 4'h0;
			txbyte    <= 8'h00;
			rxsh      <= 8'h00;
			slave_ack <= 1'b0;
			rdata     <= 8'h00;
			busy      <= 1'b0;
			nack      <= 1'b0;
			link.scl_oe_n_h <= 1'b1;
			link.sda_oe_n_h <= 1'b1;
		end else if (go) begin
			state  <= H_START;
			phase  <= 2'h0;
			byte_n <= 2'h0;
			bit_n  <= 4'h0;
			busy   <= 1'b1;
			nack   <= 1'b0;
			txbyte <= {TYPE_CODE, pwdata[CMD_CS_LSB +: 3], pwdata[CMD_RW_BIT]};
		end else if (tick) begin
			phase <= phase + 2'h1;
			case (state)
				H_START: begin
					if (phase == 2'h1) begin
						link.sda_oe_n_h <= 1'b0;
					end else if (phase == 2'h2) begin
						link.scl_oe_n_h <= 1'b0;
					end else if (phase == 2'h3) begin
						state <= H_BIT;
					end
				end
				H_BIT: begin
					if (phase == 2'h0) begin
						// Data moves a quarter into the low phase
						link.sda_oe_n_h <= (bit_n == 4'd8) | rx_mode | txbyte[7];
					end else if (phase == 2'h1) begin
						link.scl_oe_n_h <= 1'b1;
					end else if (phase == 2'h2) begin
						if (bit_n == 4'd8) begin
							slave_ack <= ~sda_s;
						end else begin
							rxsh   <= {rxsh[6:0], sda_s};
							txbyte <= {txbyte[6:0], 1'b0};
						end
					end else begin
						link.scl_oe_n_h <= 1'b0;
						bit_n           <= bit_n + 4'd1;
						if (bit_n == 4'd8) begin
							bit_n <= 4'h0;
							if (!rx_mode && !slave_ack) begin
								nack  <= 1'b1;
								state <= H_STOP;
							end else if (last_byte) begin
								if (rx_mode) begin
									rdata <= rxsh;
								end
								state <= H_STOP;
							end else begin
								byte_n <= byte_n + 2'h1;
								txbyte <= (byte_n == 2'h0) ? {1'b0, addr} : wdata;
							end
						end
					end
				end
				H_STOP: begin
					if (phase == 2'h0) begin
						link.sda_oe_n_h <= 1'b0;
					end else if (phase == 2'h1) begin
						link.scl_oe_n_h <= 1'b1;
					end else if (phase == 2'h2) begin
						link.sda_oe_n_h <= 1'b1;
					end else begin
						state <= H_IDLE;
						busy  <= 1'b0;
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	// Open-drain: both lines only ever pulled low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			link.scl_out_h <= 1'b0;
			link.sda_out_h <= 1'b0;
		end else begin
			link.scl_out_h <= 1'b0;
			link.sda_out_h <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== esfe_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface esfe_link_if;
	logic scl_out_h;
	logic scl_oe_n_h;
	logic sda_out_h;
	logic sda_oe_n_h;
	logic sda_out_d;
	logic sda_oe_n_d;
	logic scl;
	logic sda;

	// Open-drain lines with pull-up: low only while someone pulls
	assign scl = scl_oe_n_h | scl_out_h;
	assign sda = (sda_oe_n_h | sda_out_h) & (sda_oe_n_d | sda_out_d);

	modport dev (
		input  scl,
		input  sda,
		output sda_out_d,
		output sda_oe_n_d
	);

	modport host (
		input  sda,
		output scl_out_h,
		output scl_oe_n_h,
		output sda_out_h,
		output sda_oe_n_h
	);
endinterface
`default_nettype wire

// ===== esfe_pkg.sv
package esfe_pkg;

	// Arbitrary value for the fixed type code
	localparam logic [3:0] TYPE_CODE          = 4'hc;

	localparam int         CLK_HZ             = 100_000_000;
	localparam int         WRITE_CYCLE_MS     = 5;
	localparam int         WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * (CLK_HZ / 1000);
	localparam int         SCL_QUARTER_CYCLES = 5;

	localparam int         MEM_BYTES          = 128;
	localparam int         PAGE_BYTES         = 16;
	localparam int         PROTECT_BIT        = 6;
	localparam logic [6:0] RESET_PTR          = 7'h00;

	localparam logic [7:0] REG_CMD            = 8'h00;
	localparam logic [7:0] REG_ADDR           = 8'h04;
	localparam logic [7:0] REG_WDATA          = 8'h08;
	localparam logic [7:0] REG_STATUS         = 8'h0c;

	localparam int         CMD_GO_BIT         = 0;
	localparam int         CMD_RW_BIT         = 1;
	localparam int         CMD_CS_LSB         = 2;
	localparam int         STATUS_BUSY_BIT    = 0;
	localparam int         STATUS_NACK_BIT    = 1;
	localparam int         STATUS_RDATA_LSB   = 8;

endpackage

// ===== esfe_props.sv
`timescale 1ns/1ps
`default_nettype none
module esfe_props
	import esfe_pkg::*;
#(
	parameter int WRITE_CYCLE = 1000
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_out_d,
	input wire logic sda_oe_n_d,
	input wire logic chip_select_strap_bit0,
	input wire logic chip_select_strap_bit1,
	input wire logic chip_select_strap_bit2,
	input wire logic busy
);
	// ----------------------------------------
	// Bus follower: tracks bit slots on the wire
	// ----------------------------------------
	logic        scl_q, sda_q, rise, start, stop, match;
	logic        in_ctrl, addr_wr, addr_rd;
	logic [3:0]  bitn;
	logic [7:0]  shreg;
	logic [31:0] busy_cnt;

	assign rise  = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop  = scl & scl_q & ~sda_q & sda;
	// A busy device must refuse even its own control byte
	assign match = (shreg[7:4] == TYPE_CODE) && !busy &&
		(shreg[3:1] == {chip_select_strap_bit2, chip_select_strap_bit1, chip_select_strap_bit0});

	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || start || stop) begin
			bitn    <= 4'h0;
			in_ctrl <= start;
			shreg   <= 8'h00;
		end else if (rise) begin
			bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
			if (bitn < 4'h8) begin
				shreg <= {shreg[6:0], sda};
			end
			if (bitn == 4'h8) begin
				in_ctrl <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || start || stop) begin
			addr_wr <= 1'b0;
			addr_rd <= 1'b0;
		end else if (rise && bitn == 4'h8 && in_ctrl) begin
			addr_wr <= match & ~shreg[0];
			addr_rd <= match & shreg[0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || !busy) begin
			busy_cnt <= 32'h0;
		end else begin
			busy_cnt <= busy_cnt + 32'h1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	open_drain_a: assert property (!sda_oe_n_d |-> !sda_out_d)
		else $error("device drives the data line high");
	change_low_a: assert property ($changed(sda_oe_n_d) |-> !scl && !$past(scl))
		else $error("device changed the data line while the clock was high");
	ack_hold_a: assert property ($rose(scl) && !sda_oe_n_d |-> (!sda_oe_n_d && !sda) [*8])
		else $error("device pull not held through the clock high phase");
	busy_quiet_a: assert property (busy |-> sda_oe_n_d)
		else $error("device pulled the data line while programming");
	ctrl_ack_a: assert property (rise && bitn == 4'h8 && in_ctrl |-> sda_oe_n_d == !match)
		else $error("wrong answer to the control byte");
	data_ack_a: assert property (rise && bitn == 4'h8 && !in_ctrl && addr_wr |-> !sda_oe_n_d)
		else $error("received byte not acknowledged");
	nack_release_a: assert property (rise && bitn == 4'h8 && !in_ctrl && addr_rd |-> sda_oe_n_d [*8])
		else $error("device kept the data line after the final read byte");
	stop_busy_a: assert property (stop && addr_wr |-> ##[1:8] busy)
		else $error("stop after a write did not start the write cycle");
	write_time_a: assert property ($fell(busy) |-> busy_cnt >= WRITE_CYCLE - 1 && busy_cnt <= WRITE_CYCLE + 1)
		else $error("write cycle length wrong");
endmodule
`default_nettype wire

// ===== esfe_sync.sv
`timescale 1ns/1ps
`default_nettype none
module esfe_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '1
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta <= INIT;
			q    <= INIT;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire
